// ===== inc/flr_defs.svh
// constants of the fault latch and mask register block: offsets, field layouts,
// reset values and timing counts; assumes an 8-bit internal register port.
//
// Overview of operation
// RULE1: bit 7 of the supply fault log is set once any of the twelve monitored functions changed level since the logs were last read.
// RULE2: bits 6 to 0 of the supply fault log show faults on positive supplies four to one, the high-voltage supply, then bipolar supplies two and one.
// RULE3: bits 3 to 0 of the input fault log are set when general logic inputs four to one changed level since the logs were last read.
// RULE4: bit 4 of the input fault log is set when the watchdog detector output changed level since the last read, and bits 7 to 5 are reserved.
// RULE5: the supply fault log is read-only at 0xDC and powers up as 0x00.
// RULE6: the input fault log is read-only at 0xDD and powers up as 0x00.
// RULE7: a one in bits 6 to 0 of the supply mask makes the matching supply fault ignored and never logged.
// RULE8: a one in bits 4 to 0 of the input mask makes a level change on the watchdog output or matching general input ignored and not logged.
// RULE9: the supply mask at 0x9D and the input mask at 0x9E are read/write, power up as 0x00, and their top bits are unused.
// RULE10: while the summary change flag is set the log contents are frozen until they are cleared.
// RULE11: reading the input fault log clears both logs, so the host reads it after the supply fault log.
// RULE12: the summary change flag cannot be masked and no mask bit belongs to it.
// RULE13: reserved bits of all four registers read as zero and writes to them are ignored.
`ifndef FLR_DEFS_SVH
`define FLR_DEFS_SVH

`define FLR_ADDR_SUPPLY_IGNORE 8'h9D
`define FLR_ADDR_INPUT_IGNORE 8'h9E
`define FLR_ADDR_SUPPLY_LOG 8'hDC
`define FLR_ADDR_INPUT_LOG 8'hDD

`define FLR_RST_SUPPLY_IGNORE 8'h00
`define FLR_RST_INPUT_IGNORE 8'h00
`define FLR_RST_SUPPLY_LOG 7'h00
`define FLR_RST_INPUT_LOG 5'h00
`define FLR_RD_IDLE 8'h00

`define FLR_SUPPLY_BITS 8'h7F
`define FLR_INPUT_BITS 8'h1F
`define FLR_SUMMARY_BIT 7
`define FLR_WATCHDOG_BIT 4

`define FLR_NUM_SUPPLY 7
`define FLR_NUM_INPUT 5
`define FLR_NUM_MON 12

// cycles after reset release before monitored levels are trusted (two sync stages + one)
`define FLR_PRIME_CYCLES 2'h3

`endif

// ===== inc/flr_pkg.sv
// types of the fault latch and mask register block.
// assumes flr_defs.svh is on the include path.
`include "flr_defs.svh"

package flr_pkg;

	// levels of the detectors outside this block, bit order as in the logs
	typedef struct packed {
		logic watchdogDetectorOutput;
		logic [3:0] generalLogicInput;
		logic [6:0] supplyFaultDetector;
	} flr_mon_type;

	// one access on the internal register port
	typedef struct packed {
		logic [7:0] addr;
		logic wrEn;
		logic rdEn;
		logic [7:0] wrData;
	} flr_req_type;

	// one answer on the internal register port
	typedef struct packed {
		logic rdValid;
		logic [7:0] rdData;
	} flr_rsp_type;

	typedef enum logic {
		FLR_TRACK = 1'b0,
		FLR_FROZEN = 1'b1
	} flr_state_type;

endpackage

// ===== rtl/flr_sync.sv
// two-stage level synchroniser bank for the monitored detector levels.
// assumes a synchronous active-low reset already released in the clk_sys domain.
`timescale 1ns/1ns
`default_nettype none

module flr_sync #(
	parameter int WIDTH = 12
) (
	input wire logic clk_sys,
	input wire logic rstSync_n,
	input wire logic [WIDTH-1:0] asyncIn,
	output logic [WIDTH-1:0] syncOut
);

	logic [WIDTH-1:0] meta_ff;
	logic [WIDTH-1:0] sync_ff;

	// first stage feeds the second stage only
	always_ff @(posedge clk_sys or negedge rstSync_n) begin
		if (!rstSync_n) begin
			meta_ff <= '0;
			sync_ff <= '0;
		end else begin
			meta_ff <= asyncIn;
			sync_ff <= meta_ff;
		end
	end

	assign syncOut = sync_ff;

endmodule

`default_nettype wire

// ===== rtl/flr_fault_latch.sv
// fault latch and mask registers: two latched fault logs, two mask registers.
// assumes the serial interface hands over single-cycle register accesses on
// clk_sys and that detector levels may come from any domain.
// limitation: changes that arrive while the logs are frozen are lost, not queued;
// the host sees only the first event since its last clearing read.
`timescale 1ns/1ns
`default_nettype none
`include "flr_defs.svh"

module flr_fault_latch (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire flr_pkg::flr_mon_type monIn,
	input wire flr_pkg::flr_req_type regReq,
	output flr_pkg::flr_rsp_type regRsp,
	output logic summaryChangeFlag
);

	// reset release through two flip-flops
	// assertion stays asynchronous so a brown-out clears the logs at once
	logic [1:0] rstPipe_ff;
	logic rstSync_n;

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			rstPipe_ff <= 2'h0;
		end else begin
			rstPipe_ff <= {rstPipe_ff[0], 1'b1};
		end
	end

	assign rstSync_n = rstPipe_ff[1];

	// detector levels; the bits settle independently, which is harmless because
	// every function is judged on its own bit
	logic [`FLR_NUM_MON-1:0] monSync;

	flr_sync #(
		.WIDTH(`FLR_NUM_MON)
	) u_sync (
		.clk_sys(clk_sys),
		.rstSync_n(rstSync_n),
		.asyncIn(monIn),
		.syncOut(monSync)
	);

	// address decode used by the mask write strobes and the clearing read
	function automatic logic addrIs(input logic [7:0] addr, input logic [7:0] target);
		addrIs = (addr == target);
	endfunction

	// mask registers
	logic [6:0] supplyIgnore_ff;
	logic [4:0] inputIgnore_ff;
	logic [6:0] nxt_supplyIgnore;
	logic [4:0] nxt_inputIgnore;

	// one write strobe per mask; writes to the logs or unmapped addresses hit nothing
	logic wrSupplyIgnore;
	logic wrInputIgnore;

	assign wrSupplyIgnore = regReq.wrEn && addrIs(regReq.addr, `FLR_ADDR_SUPPLY_IGNORE);
	assign wrInputIgnore = regReq.wrEn && addrIs(regReq.addr, `FLR_ADDR_INPUT_IGNORE);

	always_comb begin
		nxt_supplyIgnore = supplyIgnore_ff;
		nxt_inputIgnore = inputIgnore_ff;
		if (wrSupplyIgnore) begin
			nxt_supplyIgnore = regReq.wrData[6:0]; // RULE9 RULE13
		end
		if (wrInputIgnore) begin
			nxt_inputIgnore = regReq.wrData[4:0]; // RULE9 RULE13
		end
	end

	// masks take effect from the cycle after the write
	always_ff @(posedge clk_sys or negedge rstSync_n) begin
		if (!rstSync_n) begin
			supplyIgnore_ff <= 7'(`FLR_RST_SUPPLY_IGNORE);
			inputIgnore_ff <= 5'(`FLR_RST_INPUT_IGNORE);
		end else begin
			supplyIgnore_ff <= nxt_supplyIgnore;
			inputIgnore_ff <= nxt_inputIgnore;
		end
	end

	// change detection; held off until the sync pipeline carries real levels,
	// otherwise a detector already high at power-on would look like a change
	logic [1:0] primeCnt_ff;
	logic [1:0] nxt_primeCnt;
	logic [`FLR_NUM_MON-1:0] prevMon_ff;
	logic [`FLR_NUM_MON-1:0] nxt_prevMon;
	logic primed;

	assign primed = (primeCnt_ff == `FLR_PRIME_CYCLES);

	always_comb begin
		nxt_primeCnt = primed ? primeCnt_ff : primeCnt_ff + 2'h1;
		nxt_prevMon = monSync;
	end

	always_ff @(posedge clk_sys or negedge rstSync_n) begin
		if (!rstSync_n) begin
			primeCnt_ff <= 2'h0;
			prevMon_ff <= '0;
		end else begin
			primeCnt_ff <= nxt_primeCnt;
			prevMon_ff <= nxt_prevMon;
		end
	end

	logic [`FLR_NUM_MON-1:0] ignoreAll;
	logic [`FLR_NUM_MON-1:0] unmaskedChange;
	logic anyChange;

	// the summary flag has no mask bit of its own
	assign ignoreAll = {inputIgnore_ff, supplyIgnore_ff}; // RULE12

	// one detector per monitored function; a masked function is dropped here,
	// before it can freeze the logs, so it never reaches either log
	for (genvar i = 0; i < `FLR_NUM_MON; i++) begin : g_change
		logic levelMoved;

		assign levelMoved = monSync[i] ^ prevMon_ff[i];
		assign unmaskedChange[i] = primed && levelMoved && !ignoreAll[i]; // RULE7 RULE8
	end

	assign anyChange = |unmaskedChange; // RULE1

	// fault logs
	flr_pkg::flr_state_type state_ff;
	flr_pkg::flr_state_type nxt_state;
	logic [6:0] supplyLog_ff;
	logic [6:0] nxt_supplyLog;
	logic [4:0] inputLog_ff;
	logic [4:0] nxt_inputLog;
	logic clearReq;
	logic logOpen;

	assign clearReq = regReq.rdEn && addrIs(regReq.addr, `FLR_ADDR_INPUT_LOG); // RULE11
	// a change in the clearing cycle reopens and relatches at once: set beats clear
	assign logOpen = (state_ff == flr_pkg::FLR_TRACK) || clearReq; // RULE10

	always_comb begin
		nxt_state = state_ff;
		nxt_supplyLog = supplyLog_ff;
		nxt_inputLog = inputLog_ff;
		if (logOpen) begin
			// supply bits follow the detector level until a change freezes them
			nxt_supplyLog = monSync[6:0] & ~supplyIgnore_ff; // RULE2 RULE7
			// input bits keep only the changes seen on the freezing edge
			nxt_inputLog = unmaskedChange[11:7]; // RULE3 RULE4 RULE8
			unique case (anyChange)
				1'b1: nxt_state = flr_pkg::FLR_FROZEN; // RULE1 RULE10
				1'b0: nxt_state = flr_pkg::FLR_TRACK; // RULE11
			endcase
		end
	end

	// while frozen only the clearing read moves the state or the logs
	always_ff @(posedge clk_sys or negedge rstSync_n) begin
		if (!rstSync_n) begin
			state_ff <= flr_pkg::FLR_TRACK;
			supplyLog_ff <= 7'(`FLR_RST_SUPPLY_LOG);
			inputLog_ff <= 5'(`FLR_RST_INPUT_LOG);
		end else begin
			state_ff <= nxt_state;
			supplyLog_ff <= nxt_supplyLog;
			inputLog_ff <= nxt_inputLog;
		end
	end

	// read path; data is the value before any clear from the same read
	logic [7:0] supplyLogView;
	logic [7:0] inputLogView;
	logic [7:0] supplyIgnoreView;
	logic [7:0] inputIgnoreView;
	logic [7:0] rdData_ff;
	logic [7:0] nxt_rdData;
	logic rdValid_ff;
	logic nxt_rdValid;

	// masked bits read zero even if the mask was set after the log froze
	assign supplyLogView = {(state_ff == flr_pkg::FLR_FROZEN),
		supplyLog_ff & ~supplyIgnore_ff}; // RULE1 RULE2 RULE7
	assign inputLogView = {3'h0, inputLog_ff & ~inputIgnore_ff}; // RULE4 RULE8 RULE13
	// unused top bits of the masks are not stored, so they cannot read back as one
	assign supplyIgnoreView = {1'b0, supplyIgnore_ff}; // RULE9 RULE13
	assign inputIgnoreView = {3'h0, inputIgnore_ff}; // RULE9 RULE13

	// unmapped reads still answer, with zero, so the host never waits on a reply
	always_comb begin
		nxt_rdValid = regReq.rdEn;
		nxt_rdData = `FLR_RD_IDLE;
		if (regReq.rdEn) begin
			unique case (regReq.addr)
				`FLR_ADDR_SUPPLY_IGNORE: nxt_rdData = supplyIgnoreView; // RULE9 RULE13
				`FLR_ADDR_INPUT_IGNORE: nxt_rdData = inputIgnoreView; // RULE9 RULE13
				`FLR_ADDR_SUPPLY_LOG: nxt_rdData = supplyLogView; // RULE5
				`FLR_ADDR_INPUT_LOG: nxt_rdData = inputLogView; // RULE6
				default: nxt_rdData = `FLR_RD_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge rstSync_n) begin
		if (!rstSync_n) begin
			rdData_ff <= `FLR_RD_IDLE;
			rdValid_ff <= 1'b0;
		end else begin
			rdData_ff <= nxt_rdData;
			rdValid_ff <= nxt_rdValid;
		end
	end

	assign regRsp.rdValid = rdValid_ff;
	assign regRsp.rdData = rdData_ff;
	// the flag is the state bit itself, so it cannot disagree with log bit 7
	assign summaryChangeFlag = (state_ff == flr_pkg::FLR_FROZEN); // RULE1

endmodule

`default_nettype wire

// ===== dv/flr_fault_latch_sva.sv
// checker for the fault latch register port and summary change flag.
// assumes it is bound to flr_fault_latch from the bench top.
`timescale 1ns/1ns
`default_nettype none
`include "flr_defs.svh"

module flr_fault_latch_sva (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire flr_pkg::flr_mon_type monIn,
	input wire flr_pkg::flr_req_type regReq,
	input wire flr_pkg::flr_rsp_type regRsp,
	input wire logic summaryChangeFlag
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	logic rdIn;
	logic rdSup;
	logic rdM1;
	logic rdM2;
	assign rdIn = regReq.rdEn && regReq.addr == `FLR_ADDR_INPUT_LOG;
	assign rdSup = regReq.rdEn && regReq.addr == `FLR_ADDR_SUPPLY_LOG;
	assign rdM1 = regReq.rdEn && regReq.addr == `FLR_ADDR_SUPPLY_IGNORE;
	assign rdM2 = regReq.rdEn && regReq.addr == `FLR_ADDR_INPUT_IGNORE;
	// five quiet samples cover the two sync stages and the compare stage
	sequence s_quiet;
		$stable(monIn) [*5];
	endsequence
	property p_rd_answer; regReq.rdEn |=> regRsp.rdValid; endproperty
	property p_rd_idle; !regReq.rdEn |=> !regRsp.rdValid; endproperty
	property p_idle_zero; !regRsp.rdValid |-> regRsp.rdData == 8'h00; endproperty
	property p_summary_rd; rdSup |=> regRsp.rdData[7] == $past(summaryChangeFlag); endproperty
	property p_inlog_rsv; rdIn |=> regRsp.rdData[7:5] == 3'h0; endproperty
	property p_mask_rsv; (rdM1 || rdM2) |=> !regRsp.rdData[7]
		&& !($past(rdM2) && regRsp.rdData[6:5] != 2'h0);
	endproperty
	property p_clear; s_quiet ##0 rdIn |=> !summaryChangeFlag; endproperty
	property p_freeze; summaryChangeFlag && !rdIn |=> summaryChangeFlag; endproperty
	property p_no_spur; s_quiet ##0 !summaryChangeFlag |=> !summaryChangeFlag; endproperty
	a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
	a_rd_idle: assert property (p_rd_idle) else $error("answer without read");
	a_idle_zero: assert property (p_idle_zero) else $error("read data not idle");
	a_summary_rd: assert property (p_summary_rd) else $error("summary bit mismatch");
	a_inlog_rsv: assert property (p_inlog_rsv) else $error("input log top bits set");
	a_mask_rsv: assert property (p_mask_rsv) else $error("mask top bits set");
	a_clear: assert property (p_clear) else $error("flag not cleared");
	a_freeze: assert property (p_freeze) else $error("flag dropped");
	a_no_spur: assert property (p_no_spur) else $error("flag without change");
endmodule
`default_nettype wire

// ===== dv/flr_fault_latch_tb_top.sv
// bench top for flr_fault_latch: register reads, writes and detector levels.
// assumes the checker module is compiled before this file.
`timescale 1ns/1ns
`default_nettype none
`include "flr_defs.svh"

module flr_fault_latch_tb_top;
	logic clk_sys = 1'b0;
	logic resetn = 1'b0;
	flr_pkg::flr_mon_type mon = '0;
	flr_pkg::flr_req_type req = '0;
	flr_pkg::flr_rsp_type rsp;
	logic flag;
	int n_fail = 0;
	int n_checks = 0;
	logic [7:0] addrs [5] = '{8'h9D, 8'h9E, 8'hDC, 8'hDD, 8'h00};
	always #5 clk_sys = ~clk_sys;
	flr_fault_latch u_dut (.clk_sys(clk_sys), .resetn(resetn), .monIn(mon), .regReq(req),
		.regRsp(rsp), .summaryChangeFlag(flag));
	task automatic chk(input logic [8:0] got, input logic [8:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// each access ends one idle cycle later so strobes never toggle twice in a step
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		req = '{addr: a, wrEn: 1'b1, rdEn: 1'b0, wrData: d};
		@(negedge clk_sys);
		req.wrEn = 1'b0;
		@(negedge clk_sys);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		req = '{addr: a, wrEn: 1'b0, rdEn: 1'b1, wrData: 8'h00};
		@(negedge clk_sys);
		req.rdEn = 1'b0;
		chk({rsp.rdValid, rsp.rdData}, {1'b1, e});
		@(negedge clk_sys);
	endtask
	task automatic setMon(input logic [11:0] v);
		mon = v;
		repeat (8) @(negedge clk_sys);
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	initial begin
		#50000;
		n_fail++;
		print_verdict();
	end
	initial begin
		repeat (2) @(negedge clk_sys);
		resetn = 1'b1;
		repeat (8) @(negedge clk_sys);
		foreach (addrs[i]) rd(addrs[i], 8'h00);
		foreach (addrs[i]) wr(addrs[i], 8'hFF);
		rd(8'h9D, 8'h7F);
		rd(8'h9E, 8'h1F);
		rd(8'hDC, 8'h00);
		rd(8'hDD, 8'h00);
		setMon(12'hFFF);
		chk({8'h00, flag}, 9'h000);
		setMon(12'h000);
		wr(8'h9D, 8'h00);
		wr(8'h9E, 8'h00);
		setMon(12'h008);
		rd(8'hDC, 8'h88);
		setMon(12'h048);
		rd(8'hDC, 8'h88);
		rd(8'hDD, 8'h00);
		chk({8'h00, flag}, 9'h000);
		setMon(12'h000);
		rd(8'hDC, 8'h80);
		rd(8'hDD, 8'h00);
		for (int i = 0; i < 5; i++) begin
			setMon(12'h080 << i);
			rd(8'hDC, 8'h80);
			rd(8'hDD, 8'h01 << i);
			setMon(12'h000);
			rd(8'hDD, 8'h01 << i);
		end
		wr(8'h9E, 8'h01);
		setMon(12'h080);
		chk({8'h00, flag}, 9'h000);
		setMon(12'h000);
		wr(8'h9D, 8'h08);
		setMon(12'h009);
		rd(8'hDC, 8'h81);
		rd(8'hDD, 8'h00);
		setMon(12'h00B);
		rd(8'hDC, 8'h83);
		// synced change reaches the compare on the very edge that takes the clearing read
		mon = 12'h00F;
		repeat (2) @(negedge clk_sys);
		rd(8'hDD, 8'h00);
		chk({8'h00, flag}, 9'h001);
		rd(8'hDC, 8'h87);
		wr(8'h9D, 8'h0A);
		rd(8'hDC, 8'h85);
		rd(8'hDD, 8'h00);
		chk({8'h00, flag}, 9'h000);
		print_verdict();
	end
endmodule

bind flr_fault_latch flr_fault_latch_sva u_sva (.clk_sys(clk_sys), .resetn(resetn),
	.monIn(monIn), .regReq(regReq), .regRsp(regRsp), .summaryChangeFlag(summaryChangeFlag));
`default_nettype wire
